// *** common/fis_pkg.sv ***
// Constants, types and register map of the flash interrupt status block
package fis_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam int unsigned FIS_ADDR_W          = 18;
    localparam logic [15:0] FIS_IDX_INT_STATUS  = 16'hF241;
    localparam logic [15:0] FIS_IDX_START_BLOCK = 16'hF24C;
    localparam logic [15:0] FIS_IDX_IRQ_CTRL    = 16'hF260;
    localparam logic [15:0] FIS_IDX_EVT_STATUS  = 16'hF261;
    localparam logic [15:0] FIS_IDX_EVT_MASK    = 16'hF262;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned FIS_BIT_MASTER = 15;
    localparam int unsigned FIS_BIT_LOAD   = 7;
    localparam int unsigned FIS_BIT_PROG   = 6;
    localparam int unsigned FIS_BIT_ERASE  = 5;
    localparam int unsigned FIS_BIT_RESET  = 4;
    localparam int unsigned FIS_BIT_POL    = 0;
    localparam int unsigned FIS_EVT_W      = 5;
    localparam int unsigned FIS_SBA_W      = 8;

    // ------------------------------------------------------------------
    // Values after reset and field masks
    // ------------------------------------------------------------------
    localparam logic [15:0] FIS_INT_COLD_RST = 16'h8080;
    localparam logic [15:0] FIS_INT_WARM_RST = 16'h8010;
    localparam logic [15:0] FIS_INT_MASK     = 16'h80F0;
    localparam logic [15:0] FIS_SBA_RST      = 16'h0000;
    localparam logic [15:0] FIS_SBA_MASK     = 16'h00FF;
    localparam logic        FIS_POL_RST      = 1'b1;
    localparam logic [4:0]  FIS_EVT_RST      = 5'h00;

    // ------------------------------------------------------------------
    // Operation command codes
    // ------------------------------------------------------------------
    localparam logic [15:0] FIS_CMD_LOAD      = 16'h0000;
    localparam logic [15:0] FIS_CMD_LOAD_SPR  = 16'h0013;
    localparam logic [15:0] FIS_CMD_PROG      = 16'h0080;
    localparam logic [15:0] FIS_CMD_PROG_SPR  = 16'h001A;
    localparam logic [15:0] FIS_CMD_PROG_CPY  = 16'h001B;
    localparam logic [15:0] FIS_CMD_ERASE     = 16'h0094;
    localparam logic [15:0] FIS_CMD_ERASE_MB  = 16'h0095;
    localparam logic [15:0] FIS_CMD_ERASE_RES = 16'h0030;
    localparam logic [15:0] FIS_CMD_RST_CORE  = 16'h00B0;
    localparam logic [15:0] FIS_CMD_RST_DEV   = 16'h00F0;
    localparam logic [15:0] FIS_CMD_RST_HOT   = 16'h00F3;
    localparam logic [15:0] FIS_CMD_UNLOCK    = 16'h0023;
    localparam logic [15:0] FIS_CMD_LOCK      = 16'h002A;
    localparam logic [15:0] FIS_CMD_LOCKTIGHT = 16'h002C;
    localparam logic [15:0] FIS_CMD_EVR       = 16'h0071;
    localparam logic [15:0] FIS_CMD_OTP       = 16'h0065;
    localparam logic [15:0] FIS_CMD_BUF_LOAD  = 16'h00E0;

    typedef enum logic [2:0] {
        FIS_CLS_NONE,
        FIS_CLS_LOAD,
        FIS_CLS_PROG,
        FIS_CLS_ERASE,
        FIS_CLS_RESET,
        FIS_CLS_AUX
    } fis_class_e;

    // Completion report from the flash controller
    typedef struct packed {
        logic        done;
        logic [15:0] cmd;
    } fis_op_s;

endpackage

// *** logic/fis_top.sv ***
// Interrupt status, start block register and Avalon-MM slave of the flash device
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ns

module fis_top
    import fis_pkg::*;
(
    // Clock, cold reset and the device's own resets
    input  wire logic                  MCLK_IN,
    input  wire logic                  SYS_RST_IN,
    input  wire logic                  WARM_RST_IN,
    input  wire logic                  HOT_RST_IN,
    // Completion strobes from the flash controller
    input  wire fis_op_s               OP_IN,
    input  wire logic                  BOOT_DONE_IN,
    // Register bus
    input  wire logic [FIS_ADDR_W-1:0] AVS_ADDRESS_IN,
    input  wire logic                  AVS_READ_IN,
    input  wire logic                  AVS_WRITE_IN,
    input  wire logic [3:0]            AVS_BYTEENABLE_IN,
    input  wire logic [31:0]           AVS_WRITEDATA_IN,
    // Outputs, all registered
    output logic      [31:0]           AVS_READDATA_OUT,
    output logic                       AVS_WAITREQUEST_OUT,
    output logic                       IRQ_OUT,
    output logic                       INT_PIN_OUT,
    output logic      [FIS_SBA_W-1:0]  PROTECT_START_BLOCK_OUT
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic fis_class_e op_class(input logic [15:0] cmd);
        unique case (cmd)
            FIS_CMD_LOAD,
            FIS_CMD_LOAD_SPR:  op_class = FIS_CLS_LOAD;
            FIS_CMD_PROG,
            FIS_CMD_PROG_SPR,
            FIS_CMD_PROG_CPY:  op_class = FIS_CLS_PROG;
            FIS_CMD_ERASE,
            FIS_CMD_ERASE_MB,
            FIS_CMD_ERASE_RES: op_class = FIS_CLS_ERASE;
            FIS_CMD_RST_CORE,
            FIS_CMD_RST_DEV,
            FIS_CMD_RST_HOT:   op_class = FIS_CLS_RESET;
            FIS_CMD_UNLOCK,
            FIS_CMD_LOCK,
            FIS_CMD_LOCKTIGHT,
            FIS_CMD_EVR,
            FIS_CMD_OTP,
            FIS_CMD_BUF_LOAD:  op_class = FIS_CLS_AUX;
            // Unknown codes raise nothing, so a stray strobe is harmless
            default:           op_class = FIS_CLS_NONE;
        endcase
    endfunction

    // Byte enables widened to the 16-bit register lanes
    function automatic logic [15:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[1]}}, {8{be[0]}}};
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [15:0]          int_status_r;
    logic [15:0]          int_status_nxt;
    logic [15:0]          start_block_r;
    logic [15:0]          start_block_nxt;
    logic                 pol_r;
    logic                 pol_nxt;
    logic [FIS_EVT_W-1:0] evt_status_r;
    logic [FIS_EVT_W-1:0] evt_status_nxt;
    logic [FIS_EVT_W-1:0] evt_mask_r;
    logic [FIS_EVT_W-1:0] evt_mask_nxt;
    logic                 warm_q_r;
    logic                 wait_r;
    logic [31:0]          rdata_r;
    logic                 wait_nxt;
    logic [31:0]          rdata_nxt;
    logic                 irq_r;
    logic                 pin_r;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic [15:0]          idx;
    logic                 req;
    logic                 wr_acc;
    logic [15:0]          wmask;
    logic [15:0]          wdata;
    logic                 wr_int;
    logic                 wr_sba;
    logic                 wr_ctrl;
    logic                 wr_evt;
    logic                 wr_mask;
    logic                 dev_rst;
    logic                 wr_ctrl_lo;
    logic                 wr_evt_lo;
    logic                 wr_mask_lo;

    assign idx     = AVS_ADDRESS_IN[FIS_ADDR_W-1:2];
    assign req     = AVS_READ_IN | AVS_WRITE_IN;
    // Write lands on the edge where waitrequest is seen low
    assign wr_acc  = AVS_WRITE_IN & ~wait_r;
    assign wmask   = lane_mask(AVS_BYTEENABLE_IN);
    assign wdata   = AVS_WRITEDATA_IN[15:0];
    assign wr_int  = wr_acc && (idx == FIS_IDX_INT_STATUS);
    assign wr_sba  = wr_acc && (idx == FIS_IDX_START_BLOCK);
    assign wr_ctrl = wr_acc && (idx == FIS_IDX_IRQ_CTRL);
    assign wr_evt  = wr_acc && (idx == FIS_IDX_EVT_STATUS);
    assign wr_mask = wr_acc && (idx == FIS_IDX_EVT_MASK);
    assign dev_rst = WARM_RST_IN | HOT_RST_IN;
    // Registers narrower than a byte (control, event status, event mask) live in lane 0 only
    assign wr_ctrl_lo = wr_ctrl && AVS_BYTEENABLE_IN[0];
    assign wr_evt_lo  = wr_evt && AVS_BYTEENABLE_IN[0];
    assign wr_mask_lo = wr_mask && AVS_BYTEENABLE_IN[0];

    // ------------------------------------------------------------------
    // Completion events
    // ------------------------------------------------------------------
    fis_class_e           cls;
    logic                 warm_release;
    logic [FIS_EVT_W-1:0] evt_set;

    assign cls          = OP_IN.done ? op_class(OP_IN.cmd) : FIS_CLS_NONE;
    assign warm_release = warm_q_r & ~WARM_RST_IN;
    assign evt_set[0]   = (cls == FIS_CLS_LOAD) | BOOT_DONE_IN;
    assign evt_set[1]   = (cls == FIS_CLS_PROG);
    assign evt_set[2]   = (cls == FIS_CLS_ERASE);
    assign evt_set[3]   = (cls == FIS_CLS_RESET) | warm_release;
    assign evt_set[4]   = (cls == FIS_CLS_AUX);

    // ------------------------------------------------------------------
    // Flag placement in the status word
    // ------------------------------------------------------------------
    logic [15:0]          flag_set;

    // Each completion flag except auxiliary has its own bit; every event also raises master
    for (genvar g = 0; g < 16; g++) begin : g_flag
        if (g == FIS_BIT_MASTER) begin : g_master
            assign flag_set[g] = |evt_set;
        end else if (g == FIS_BIT_LOAD) begin : g_load
            assign flag_set[g] = evt_set[0];
        end else if (g == FIS_BIT_PROG) begin : g_prog
            assign flag_set[g] = evt_set[1];
        end else if (g == FIS_BIT_ERASE) begin : g_erase
            assign flag_set[g] = evt_set[2];
        end else if (g == FIS_BIT_RESET) begin : g_reset
            assign flag_set[g] = evt_set[3];
        end else begin : g_rsvd
            // Reserved bits never set, so they keep reading zero
            assign flag_set[g] = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------------
    always_comb begin
        logic [15:0] clr;
        clr = wr_int ? (wmask & ~wdata) : 16'h0000;
        int_status_nxt = int_status_r & ~clr;
        // Set beats clear so a completion in the clearing cycle survives
        int_status_nxt = int_status_nxt | flag_set;
        // Device resets reload 8010h, so reset_done is never cleared by them
        int_status_nxt = int_status_nxt & FIS_INT_MASK;
        if (dev_rst) begin
            int_status_nxt = FIS_INT_WARM_RST;
        end
    end

    always_comb begin
        logic [15:0] merged;
        merged = (start_block_r & ~wmask) | (wdata & wmask);
        start_block_nxt = start_block_r;
        if (dev_rst) begin
            start_block_nxt = FIS_SBA_RST;
        end else if (wr_sba) begin
            start_block_nxt = merged & FIS_SBA_MASK;
        end
    end

    always_comb begin
        pol_nxt = pol_r;
        if (wr_ctrl_lo) begin
            pol_nxt = wdata[FIS_BIT_POL];
        end
    end

    always_comb begin
        logic [FIS_EVT_W-1:0] w1c;
        w1c = wr_evt_lo ? wdata[FIS_EVT_W-1:0] : FIS_EVT_RST;
        // Set wins over a same-cycle write of one
        evt_status_nxt = (evt_status_r & ~w1c) | evt_set;
    end

    always_comb begin
        evt_mask_nxt = evt_mask_r;
        if (wr_mask_lo) begin
            evt_mask_nxt = wdata[FIS_EVT_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Cold reset only; warm and hot act through the next values
    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            int_status_r <= FIS_INT_COLD_RST;
        end else begin
            int_status_r <= int_status_nxt;
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            start_block_r <= FIS_SBA_RST;
        end else begin
            start_block_r <= start_block_nxt;
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            pol_r <= FIS_POL_RST;
        end else begin
            pol_r <= pol_nxt;
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            evt_status_r <= FIS_EVT_RST;
        end else begin
            evt_status_r <= evt_status_nxt;
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            evt_mask_r <= FIS_EVT_RST;
        end else begin
            evt_mask_r <= evt_mask_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Warm reset release
    // ------------------------------------------------------------------
    // Release is seen one edge late, once the forced value has ended
    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            warm_q_r <= 1'b0;
        end else begin
            warm_q_r <= WARM_RST_IN;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, registered from next values so they track without lag
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(evt_status_nxt & evt_mask_nxt);
        end
    end

    // Pin leaves the chip, so it comes straight from a flop
    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            pin_r <= FIS_POL_RST ? FIS_INT_COLD_RST[FIS_BIT_MASTER]
                                 : ~FIS_INT_COLD_RST[FIS_BIT_MASTER];
        end else begin
            pin_r <= pol_nxt ? int_status_nxt[FIS_BIT_MASTER]
                             : ~int_status_nxt[FIS_BIT_MASTER];
        end
    end

    // ------------------------------------------------------------------
    // Avalon slave: one wait cycle, read data valid with waitrequest low
    // ------------------------------------------------------------------
    function automatic logic [15:0] reg_read(input logic [15:0] a);
        unique case (a)
            FIS_IDX_INT_STATUS:  reg_read = int_status_r & FIS_INT_MASK;
            FIS_IDX_START_BLOCK: reg_read = start_block_r & FIS_SBA_MASK;
            FIS_IDX_IRQ_CTRL:    reg_read = {15'h0000, pol_r};
            FIS_IDX_EVT_STATUS:  reg_read = {11'h000, evt_status_r};
            FIS_IDX_EVT_MASK:    reg_read = {11'h000, evt_mask_r};
            default:             reg_read = 16'h0000;
        endcase
    endfunction

    // One wait cycle per access gives the read mux a full period
    always_comb begin
        wait_nxt  = 1'b1;
        rdata_nxt = rdata_r;
        if (req && wait_r) begin
            wait_nxt  = 1'b0;
            rdata_nxt = AVS_READ_IN ? {16'h0000, reg_read(idx)} : 32'h0000_0000;
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            wait_r <= 1'b1;
        end else begin
            wait_r <= wait_nxt;
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Every output below is a plain flop
    assign AVS_READDATA_OUT        = rdata_r;
    assign AVS_WAITREQUEST_OUT     = wait_r;
    assign IRQ_OUT                 = irq_r;
    assign INT_PIN_OUT             = pin_r;
    assign PROTECT_START_BLOCK_OUT = start_block_r[FIS_SBA_W-1:0];

endmodule

// *** tb/fis_top_sva.sv ***
// Port checker of the flash interrupt status block
`timescale 1ns/1ns
module fis_top_sva
    import fis_pkg::*;
(
    input wire logic                  MCLK_IN,
    input wire logic                  SYS_RST_IN,
    input wire logic                  WARM_RST_IN,
    input wire logic                  HOT_RST_IN,
    input wire fis_op_s               OP_IN,
    input wire logic                  BOOT_DONE_IN,
    input wire logic [FIS_ADDR_W-1:0] AVS_ADDRESS_IN,
    input wire logic                  AVS_READ_IN,
    input wire logic                  AVS_WRITE_IN,
    input wire logic [3:0]            AVS_BYTEENABLE_IN,
    input wire logic [31:0]           AVS_WRITEDATA_IN,
    input wire logic [31:0]           AVS_READDATA_OUT,
    input wire logic                  AVS_WAITREQUEST_OUT,
    input wire logic                  INT_PIN_OUT,
    input wire logic [FIS_SBA_W-1:0]  PROTECT_START_BLOCK_OUT
);
    // ------------------------------------------------------------------
    // Polarity shadow, taken from accepted host writes
    // ------------------------------------------------------------------
    logic [15:0] idx;
    logic        acc_w;
    logic        acc_r;
    logic        pol_r;
    assign idx = AVS_ADDRESS_IN[17:2];
    assign acc_w = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT;
    assign acc_r = AVS_READ_IN && !AVS_WAITREQUEST_OUT;
    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            pol_r <= FIS_POL_RST;
        end else if (acc_w && idx == FIS_IDX_IRQ_CTRL && AVS_BYTEENABLE_IN[0]) begin
            pol_r <= AVS_WRITEDATA_IN[FIS_BIT_POL];
        end
    end
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    // Warm release sets flags one edge after warm is last seen high, so both past edges are excluded
    sequence quiet_s;
        !OP_IN.done && !BOOT_DONE_IN && !WARM_RST_IN && !HOT_RST_IN
            && !$past(WARM_RST_IN) && !$past(WARM_RST_IN, 2);
    endsequence
    sequence clr_master_s;
        acc_w && idx == FIS_IDX_INT_STATUS && AVS_BYTEENABLE_IN[1] && !AVS_WRITEDATA_IN[15];
    endsequence
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    master_clear_a: assert property (clr_master_s and quiet_s |=> INT_PIN_OUT == !pol_r)
        else $error("master flag not cleared by host zero");
    op_sets_a: assert property (OP_IN.done && OP_IN.cmd inside {16'h0000, 16'h0013, 16'h0080,
        16'h001A, 16'h001B, 16'h0094, 16'h0095, 16'h0030, 16'h00B0, 16'h00F0, 16'h00F3}
        |=> INT_PIN_OUT == pol_r) else $error("completion did not raise master flag");
    aux_sets_a: assert property (OP_IN.done && OP_IN.cmd inside {16'h0023, 16'h002A,
        16'h002C, 16'h0071, 16'h0065, 16'h00E0} |=> INT_PIN_OUT == pol_r)
        else $error("auxiliary completion did not raise master flag");
    boot_sets_a: assert property (BOOT_DONE_IN |=> INT_PIN_OUT == pol_r)
        else $error("boot completion did not raise master flag");
    warm_hold_a: assert property (WARM_RST_IN || HOT_RST_IN
        |=> INT_PIN_OUT == pol_r && PROTECT_START_BLOCK_OUT == 8'h00)
        else $error("warm or hot reset value wrong");
    cold_dflt_a: assert property ($fell(SYS_RST_IN) |-> INT_PIN_OUT
        && PROTECT_START_BLOCK_OUT == 8'h00) else $error("cold reset value wrong");
    sba_write_a: assert property (acc_w && idx == FIS_IDX_START_BLOCK && AVS_BYTEENABLE_IN[0]
        && !WARM_RST_IN && !HOT_RST_IN
        |=> PROTECT_START_BLOCK_OUT == $past(AVS_WRITEDATA_IN[7:0]))
        else $error("start block output not updated");
    stat_rsvd_a: assert property (acc_r && idx == FIS_IDX_INT_STATUS
        |-> (AVS_READDATA_OUT & ~32'h0000_80F0) == 32'h0000_0000)
        else $error("reserved status bits not zero");
    sba_rsvd_a: assert property (acc_r && idx == FIS_IDX_START_BLOCK
        |-> AVS_READDATA_OUT[31:8] == 24'h00_0000) else $error("start block upper bits not zero");
endmodule
bind fis_top fis_top_sva chk (.*);

// *** tb/fis_host_model.sv ***
// Avalon-MM host model driving the register bus
`timescale 1ns/1ns
module fis_host_model
    import fis_pkg::*;
(
    input  wire logic                  clk_in,
    input  wire logic                  waitrequest_in,
    input  wire logic [31:0]           readdata_in,
    output logic      [FIS_ADDR_W-1:0] address_out,
    output logic                       read_out,
    output logic                       write_out,
    output logic      [3:0]            byteenable_out,
    output logic      [31:0]           writedata_out
);
    initial begin
        address_out = '0;
        read_out = 1'b0;
        write_out = 1'b0;
        byteenable_out = 4'h0;
        writedata_out = 32'h0000_0000;
    end
    // Held until waitrequest is seen low; no cycle count assumed
    task automatic xfer(input logic wr, input logic [15:0] idx, input logic [15:0] wd,
                        output logic [15:0] rdata);
        @(posedge clk_in);
        address_out <= {idx, 2'b00};
        writedata_out <= {16'h0000, wd};
        byteenable_out <= 4'h3;
        read_out <= !wr;
        write_out <= wr;
        do @(posedge clk_in); while (waitrequest_in !== 1'b0);
        rdata = readdata_in[15:0];
        read_out <= 1'b0;
        write_out <= 1'b0;
        writedata_out <= ~writedata_out;
    endtask
endmodule

// *** tb/tb_top.sv ***
// Self-checking testbench of the flash interrupt status block
`timescale 1ns/1ns
module tb_top
    import fis_pkg::*;
;
    logic                  mclk = 1'b0;
    logic                  rst = 1'b1;
    logic                  warm = 1'b0;
    logic                  hot = 1'b0;
    fis_op_s               op = '0;
    logic                  boot = 1'b0;
    logic [FIS_ADDR_W-1:0] addr;
    logic                  rd_s;
    logic                  wr_s;
    logic [3:0]            be;
    logic [31:0]           wd;
    logic [31:0]           rdata;
    logic                  wait_s;
    logic                  irq;
    logic                  pin;
    logic [FIS_SBA_W-1:0]  protect_start_block;
    int                    miscompares = 0;
    int                    checked = 0;
    logic [15:0]           cmds [17] = '{FIS_CMD_LOAD, FIS_CMD_LOAD_SPR, FIS_CMD_PROG,
        FIS_CMD_PROG_SPR, FIS_CMD_PROG_CPY, FIS_CMD_ERASE, FIS_CMD_ERASE_MB, FIS_CMD_ERASE_RES,
        FIS_CMD_RST_CORE, FIS_CMD_RST_DEV, FIS_CMD_RST_HOT, FIS_CMD_UNLOCK, FIS_CMD_LOCK,
        FIS_CMD_LOCKTIGHT, FIS_CMD_EVR, FIS_CMD_OTP, FIS_CMD_BUF_LOAD};
    always #4 mclk = ~mclk;
    fis_top dut (.MCLK_IN(mclk), .SYS_RST_IN(rst), .WARM_RST_IN(warm), .HOT_RST_IN(hot),
        .OP_IN(op), .BOOT_DONE_IN(boot), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd_s),
        .AVS_WRITE_IN(wr_s), .AVS_BYTEENABLE_IN(be), .AVS_WRITEDATA_IN(wd),
        .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wait_s), .IRQ_OUT(irq),
        .INT_PIN_OUT(pin), .PROTECT_START_BLOCK_OUT(protect_start_block));
    fis_host_model host (.clk_in(mclk), .waitrequest_in(wait_s), .readdata_in(rdata),
        .address_out(addr), .read_out(rd_s), .write_out(wr_s), .byteenable_out(be),
        .writedata_out(wd));
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [15:0] idx, input logic [15:0] exp);
        logic [15:0] d;
        host.xfer(1'b0, idx, 16'h0000, d);
        chk(d, exp);
    endtask
    task automatic wr(input logic [15:0] idx, input logic [15:0] data);
        logic [15:0] d;
        host.xfer(1'b1, idx, data, d);
    endtask
    task automatic pulse(input logic [15:0] cmd);
        @(posedge mclk);
        op <= {1'b1, cmd};
        @(posedge mclk);
        op.done <= 1'b0;
    endtask
    task automatic t_cold();
        rd(FIS_IDX_INT_STATUS, 16'h8080);
        rd(FIS_IDX_START_BLOCK, 16'h0000);
        rd(16'hF250, 16'h0000);
        chk({15'h0000, pin}, 16'h0001);
        wr(FIS_IDX_INT_STATUS, 16'hFFFF);
        rd(FIS_IDX_INT_STATUS, 16'h8080);
        wr(FIS_IDX_INT_STATUS, 16'h0000);
        rd(FIS_IDX_INT_STATUS, 16'h0000);
    endtask
    task automatic t_cmds();
        logic [15:0] e;
        for (int i = 0; i < 17; i++) begin
            e = (i < 2) ? 16'h0080 : (i < 5) ? 16'h0040 : (i < 8) ? 16'h0020 :
                (i < 11) ? 16'h0010 : 16'h0000;
            pulse(cmds[i]);
            rd(FIS_IDX_INT_STATUS, 16'h8000 | e);
            wr(FIS_IDX_INT_STATUS, 16'h0000);
        end
        pulse(16'h0090);
        rd(FIS_IDX_INT_STATUS, 16'h0000);
        @(posedge mclk);
        boot <= 1'b1;
        @(posedge mclk);
        boot <= 1'b0;
        rd(FIS_IDX_INT_STATUS, 16'h8080);
    endtask
    task automatic t_pin();
        wr(FIS_IDX_IRQ_CTRL, 16'h0000);
        rd(FIS_IDX_IRQ_CTRL, 16'h0000);
        chk({15'h0000, pin}, 16'h0000);
        wr(FIS_IDX_INT_STATUS, 16'h0000);
        rd(FIS_IDX_INT_STATUS, 16'h0000);
        chk({15'h0000, pin}, 16'h0001);
        wr(FIS_IDX_IRQ_CTRL, 16'h0001);
        wr(FIS_IDX_START_BLOCK, 16'hABCD);
        rd(FIS_IDX_START_BLOCK, 16'h00CD);
        chk({8'h00, protect_start_block}, 16'h00CD);
    endtask
    task automatic t_rst(input logic w, input logic h);
        pulse(FIS_CMD_PROG);
        @(posedge mclk);
        warm <= w;
        hot <= h;
        @(posedge mclk);
        warm <= 1'b0;
        hot <= 1'b0;
        rd(FIS_IDX_INT_STATUS, 16'h8010);
        rd(FIS_IDX_START_BLOCK, 16'h0000);
    endtask
    task automatic t_irq();
        wr(FIS_IDX_EVT_STATUS, 16'h001F);
        wr(FIS_IDX_EVT_MASK, 16'h0002);
        rd(FIS_IDX_EVT_MASK, 16'h0002);
        chk({15'h0000, irq}, 16'h0000);
        pulse(FIS_CMD_PROG);
        rd(FIS_IDX_EVT_STATUS, 16'h0002);
        chk({15'h0000, irq}, 16'h0001);
        wr(FIS_IDX_EVT_STATUS, 16'h0002);
        rd(FIS_IDX_EVT_STATUS, 16'h0000);
        chk({15'h0000, irq}, 16'h0000);
        pulse(FIS_CMD_ERASE);
        rd(FIS_IDX_EVT_STATUS, 16'h0004);
        chk({15'h0000, irq}, 16'h0000);
    endtask
    task automatic end_of_test();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        t_cold();
        t_cmds();
        t_pin();
        t_rst(1'b1, 1'b0);
        t_rst(1'b0, 1'b1);
        t_irq();
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        end_of_test();
    end
endmodule
